// ==== logic/mpac_ctrl.sv ====
// Summary of operation
// - Volt annunciator lit in voltage or diode function.
// - Ampere annunciator lit in current function.
// - Ohm annunciator lit in resistance or continuity function.
// - Farad annunciator lit in capacitance function.
// - Continuity symbol only in continuity, diode symbol only in diode.
// - Percent lit in duty cycle, hertz lit in frequency function.
// - Each adapter annunciator lit only while its adapter mode is active.
// - DC annunciator in DC volt/current, AC annunciator in AC volt/current.
// - Auto annunciator with auto ranging, manual annunciator with manual.
// - Hold, relative, max/min, zero, surge lit exactly while enabled.
// - Capacitance shows milli, micro or nano prefix by range order.
// - Milli prefix for volt/current milli ranges, micro for microamp.
// - Resistance shows mega or kilo prefix by range order.
// - Temperature shows Celsius or Fahrenheit by selected unit.
// - Power-off and serial-output annunciators follow their enables.
// - Four phases zero, auto-zero, integrate, de-integrate; fast is tenfold.
// - Phases 60, 24, 100, 166 ms slow; one tenth at high speed.
// - Meter and auto clamp current integrate 1000 ms slow, 100 ms fast.
// - Frequency and duty mode ends one measurement every 1.05 s.
// - Auto frequency range change shortens measurement cycle tenfold.
`timescale 1ns/100ps
module mpac_ctrl
    import mpac_pkg::*;
#(
    parameter int unsigned ZI_CYC   = ZI_CYC_DEF,
    parameter int unsigned AZ_CYC   = AZ_CYC_DEF,
    parameter int unsigned INT_CYC  = INT_CYC_DEF,
    parameter int unsigned INTL_CYC = INTL_CYC_DEF,
    parameter int unsigned DEINTEGRATE_PHASE_CYC = DEINTEGRATE_PHASE_CYC_DEF,
    parameter int unsigned MEAS_CYC = MEAS_CYC_DEF
) (
    // Clock and reset
    input  wire logic       CLK,
    input  wire logic       NRST,
    // Mode and range state
    input  wire logic [3:0] FUNC_SEL,
    input  wire logic [2:0] RANGE_ORDER,
    input  wire logic       AC_MODE,
    input  wire logic       AUTO_RANGE,
    input  wire logic       TEMP_CELSIUS,
    input  wire logic       HI_SPEED,
    input  wire logic       FREQ_RANGE_CHG,
    // Push functions and options
    input  wire logic       HOLD_EN,
    input  wire logic       REL_EN,
    input  wire logic       MAXMIN_EN,
    input  wire logic       ZERO_EN,
    input  wire logic       INRUSH_EN,
    input  wire logic       APO_EN,
    input  wire logic       SERIAL_EN,
    // Converter phases
    output logic            ZI_PHASE,
    output logic            AZ_PHASE,
    output logic            INT_PHASE,
    output logic            DEINT_PHASE,
    output logic            MEAS_CYCLE_END,
    // Annunciators
    output logic            ANN_VOLT,
    output logic            ANN_AMP,
    output logic            ANN_OHM,
    output logic            ANN_FARAD,
    output logic            ANN_CONT,
    output logic            ANN_DIODE,
    output logic            ANN_PCT,
    output logic            ANN_HZ,
    output logic            ANN_ADAPTER_MODE_ONE,
    output logic            ANN_ADAPTER_MODE_TWO,
    output logic            ANN_ADAPTER_MODE_THREE,
    output logic            ANN_ADAPTER_MODE_FOUR,
    output logic            ANN_DC,
    output logic            ANN_AC,
    output logic            ANN_AUTO,
    output logic            ANN_MANUAL_RANGE_FLAG,
    output logic            ANN_HOLD,
    output logic            ANN_REL,
    output logic            ANN_MAXMIN,
    output logic            ANN_ZERO,
    output logic            ANN_INRUSH,
    output logic            ANN_CAP_MILLI,
    output logic            ANN_CAP_MICRO,
    output logic            ANN_CAP_NANO,
    output logic            ANN_MILLI,
    output logic            ANN_MICRO,
    output logic            ANN_MEGA,
    output logic            ANN_KILO,
    output logic            ANN_DEGC,
    output logic            ANN_DEGF,
    output logic            ANN_APO,
    output logic            ANN_SERIAL
);

    // **************************************************
    // Parameter checks
    // **************************************************
    // Fast lengths divide by ten, so each count must survive that
    if (ZI_CYC < SPEED_RATIO || AZ_CYC < SPEED_RATIO ||
        INT_CYC < SPEED_RATIO || INTL_CYC < SPEED_RATIO ||
        DEINTEGRATE_PHASE_CYC < SPEED_RATIO || MEAS_CYC < SPEED_RATIO) begin : g_short
        $error("mpac_ctrl: phase or cycle count below ten");
    end
    if (ZI_CYC >= (1 << CNT_W) || AZ_CYC >= (1 << CNT_W) ||
        INTL_CYC >= (1 << CNT_W) || INT_CYC >= (1 << CNT_W) ||
        DEINTEGRATE_PHASE_CYC >= (1 << CNT_W) ||
        MEAS_CYC >= (1 << CNT_W)) begin : g_wide
        $error("mpac_ctrl: count does not fit the counter");
    end

    // **************************************************
    // Reset release
    // **************************************************
    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // **************************************************
    // Decoding helpers
    // **************************************************
    function automatic logic is_curr(input logic [3:0] f);
        return f == FN_CURR_DMM || f == FN_CURR_CLAMP;
    endfunction

    function automatic logic is_fcnt(input logic [3:0] f);
        return f == FN_FREQ || f == FN_DUTY;
    endfunction

    function automatic logic [CNT_W-1:0] scale(input int unsigned c,
                                               input logic fast);
        int unsigned v;
        v = fast ? c / SPEED_RATIO : c;
        return CNT_W'(v - 1);
    endfunction

    // **************************************************
    // State
    // **************************************************
    typedef struct packed {
        mpac_phase_t      phase;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] mcnt;
        logic             mend;
        mpac_seg_t        seg;
    } mpac_state_t;

    mpac_state_t s_q;
    mpac_state_t s_d;
    logic        long_int;
    logic        meas_fast;
    logic        volt_curr;

    assign long_int  = FUNC_SEL == FN_CURR_DMM ||
                       (FUNC_SEL == FN_CURR_CLAMP && AUTO_RANGE);
    assign meas_fast = AUTO_RANGE && FREQ_RANGE_CHG;
    assign volt_curr = FUNC_SEL == FN_VOLT || is_curr(FUNC_SEL);

    always_comb begin
        s_d      = s_q;
        s_d.mend = 1'b0;

        // Phase sequencer: count to zero, then load the next phase
        if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - CNT_W'(1);
        end else begin
            case (s_q.phase)
                PH_ZI: begin
                    s_d.phase = PH_AZ;
                    s_d.cnt   = scale(AZ_CYC, HI_SPEED);
                end
                PH_AZ: begin
                    s_d.phase = PH_INT;
                    s_d.cnt   = long_int ?
                                scale(INTL_CYC, HI_SPEED) :
                                scale(INT_CYC, HI_SPEED);
                end
                PH_INT: begin
                    s_d.phase = PH_DEINTEGRATE_PHASE;
                    s_d.cnt   = scale(DEINTEGRATE_PHASE_CYC, HI_SPEED);
                end
                default: begin
                    s_d.phase = PH_ZI;
                    s_d.cnt   = scale(ZI_CYC, HI_SPEED);
                end
            endcase
        end

        // Frequency measurement cycle; held at reload outside that mode
        if (!is_fcnt(FUNC_SEL)) begin
            s_d.mcnt = scale(MEAS_CYC, 1'b0);
        end else if (s_q.mcnt == '0) begin
            s_d.mend = 1'b1;
            s_d.mcnt = scale(MEAS_CYC, meas_fast);
        end else if (meas_fast &&
                     s_q.mcnt > scale(MEAS_CYC, 1'b1)) begin
            // Cut a slow cycle short as soon as the range moves
            s_d.mcnt = scale(MEAS_CYC, 1'b1);
        end else begin
            s_d.mcnt = s_q.mcnt - CNT_W'(1);
        end

        // Annunciators: a pure decode, so they move only with the inputs
        s_d.seg        = '0;
        s_d.seg.volt   = FUNC_SEL == FN_VOLT ||
                         FUNC_SEL == FN_DIODE;
        s_d.seg.amp    = is_curr(FUNC_SEL);
        s_d.seg.ohm    = FUNC_SEL == FN_OHM ||
                         FUNC_SEL == FN_CONT;
        s_d.seg.farad  = FUNC_SEL == FN_CAP;
        s_d.seg.cont   = FUNC_SEL == FN_CONT;
        s_d.seg.diode  = FUNC_SEL == FN_DIODE;
        s_d.seg.pct    = FUNC_SEL == FN_DUTY;
        s_d.seg.hz     = FUNC_SEL == FN_FREQ;
        s_d.seg.adapter_mode_one   = FUNC_SEL == FN_ADAPTER_MODE_ONE;
        s_d.seg.adapter_mode_two   = FUNC_SEL == FN_ADAPTER_MODE_TWO;
        s_d.seg.adapter_mode_three   = FUNC_SEL == FN_ADAPTER_MODE_THREE;
        s_d.seg.adapter_mode_four   = FUNC_SEL == FN_ADAPTER_MODE_FOUR;
        s_d.seg.dc     = volt_curr && !AC_MODE;
        s_d.seg.ac     = volt_curr && AC_MODE;
        s_d.seg.auto_r = AUTO_RANGE;
        s_d.seg.manual_range_flag   = !AUTO_RANGE;
        s_d.seg.hold   = HOLD_EN;
        s_d.seg.relative_function_flag    = REL_EN;
        s_d.seg.maxmin = MAXMIN_EN;
        s_d.seg.zero   = ZERO_EN;
        s_d.seg.inrush = INRUSH_EN;
        s_d.seg.cap_m  = FUNC_SEL == FN_CAP &&
                         RANGE_ORDER == RO_MILLI;
        s_d.seg.cap_u  = FUNC_SEL == FN_CAP &&
                         RANGE_ORDER == RO_MICRO;
        s_d.seg.cap_n  = FUNC_SEL == FN_CAP &&
                         RANGE_ORDER == RO_NANO;
        s_d.seg.va_m   = volt_curr && RANGE_ORDER == RO_MILLI;
        s_d.seg.cur_u  = is_curr(FUNC_SEL) &&
                         RANGE_ORDER == RO_MICRO;
        s_d.seg.meg    = FUNC_SEL == FN_OHM &&
                         RANGE_ORDER == RO_MEGA;
        s_d.seg.kilo   = FUNC_SEL == FN_OHM &&
                         RANGE_ORDER == RO_KILO;
        s_d.seg.degc   = FUNC_SEL == FN_TEMP && TEMP_CELSIUS;
        s_d.seg.degf   = FUNC_SEL == FN_TEMP && !TEMP_CELSIUS;
        s_d.seg.power_off_timer_flag    = APO_EN;
        s_d.seg.serial = SERIAL_EN;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            s_q       <= '0;
            s_q.phase <= PH_ZI;
        end else begin
            s_q <= s_d;
        end
    end

    // **************************************************
    // Outputs
    // **************************************************
    assign ZI_PHASE       = s_q.phase == PH_ZI;
    assign AZ_PHASE       = s_q.phase == PH_AZ;
    assign INT_PHASE      = s_q.phase == PH_INT;
    assign DEINT_PHASE    = s_q.phase == PH_DEINTEGRATE_PHASE;
    assign MEAS_CYCLE_END = s_q.mend;
    assign ANN_VOLT       = s_q.seg.volt;
    assign ANN_AMP        = s_q.seg.amp;
    assign ANN_OHM        = s_q.seg.ohm;
    assign ANN_FARAD      = s_q.seg.farad;
    assign ANN_CONT       = s_q.seg.cont;
    assign ANN_DIODE      = s_q.seg.diode;
    assign ANN_PCT        = s_q.seg.pct;
    assign ANN_HZ         = s_q.seg.hz;
    assign ANN_ADAPTER_MODE_ONE       = s_q.seg.adapter_mode_one;
    assign ANN_ADAPTER_MODE_TWO       = s_q.seg.adapter_mode_two;
    assign ANN_ADAPTER_MODE_THREE       = s_q.seg.adapter_mode_three;
    assign ANN_ADAPTER_MODE_FOUR       = s_q.seg.adapter_mode_four;
    assign ANN_DC         = s_q.seg.dc;
    assign ANN_AC         = s_q.seg.ac;
    assign ANN_AUTO       = s_q.seg.auto_r;
    assign ANN_MANUAL_RANGE_FLAG       = s_q.seg.manual_range_flag;
    assign ANN_HOLD       = s_q.seg.hold;
    assign ANN_REL        = s_q.seg.relative_function_flag;
    assign ANN_MAXMIN     = s_q.seg.maxmin;
    assign ANN_ZERO       = s_q.seg.zero;
    assign ANN_INRUSH     = s_q.seg.inrush;
    assign ANN_CAP_MILLI  = s_q.seg.cap_m;
    assign ANN_CAP_MICRO  = s_q.seg.cap_u;
    assign ANN_CAP_NANO   = s_q.seg.cap_n;
    assign ANN_MILLI      = s_q.seg.va_m;
    assign ANN_MICRO      = s_q.seg.cur_u;
    assign ANN_MEGA       = s_q.seg.meg;
    assign ANN_KILO       = s_q.seg.kilo;
    assign ANN_DEGC       = s_q.seg.degc;
    assign ANN_DEGF       = s_q.seg.degf;
    assign ANN_APO        = s_q.seg.power_off_timer_flag;
    assign ANN_SERIAL     = s_q.seg.serial;

    // **************************************************
    // Checks
    // **************************************************
    chk_volt_follow: assert property (@(posedge CLK) disable iff (!rst_n)
        1'b1 |=> ANN_VOLT == ($past(FUNC_SEL) == FN_VOLT ||
                              $past(FUNC_SEL) == FN_DIODE))
        else $error("volt annunciator wrong");

    chk_amp_follow: assert property (@(posedge CLK) disable iff (!rst_n)
        is_curr(FUNC_SEL) |=> ANN_AMP && !ANN_OHM)
        else $error("ampere annunciator wrong");

    chk_ohm_cont: assert property (@(posedge CLK) disable iff (!rst_n)
        FUNC_SEL == FN_CONT |=> ANN_OHM && ANN_CONT && !ANN_DIODE)
        else $error("continuity annunciators wrong");

    // Implication keeps the first edge out of reset, when both are still 0
    chk_range_pair: assert property (@(posedge CLK) disable iff (!rst_n)
        1'b1 |=> ANN_AUTO != ANN_MANUAL_RANGE_FLAG && ANN_AUTO == $past(AUTO_RANGE))
        else $error("range annunciators wrong");

    chk_phase_onehot: assert property (@(posedge CLK) disable iff (!rst_n)
        $onehot({ZI_PHASE, AZ_PHASE, INT_PHASE, DEINT_PHASE}))
        else $error("phase not one-hot");

    chk_phase_order: assert property (@(posedge CLK) disable iff (!rst_n)
        AZ_PHASE && s_q.cnt == '0 |=> INT_PHASE ##0
        s_q.cnt == ($past(long_int) ? scale(INTL_CYC, $past(HI_SPEED)) :
                    scale(INT_CYC, $past(HI_SPEED))))
        else $error("integrate phase length wrong");

    chk_zi_length: assert property (@(posedge CLK) disable iff (!rst_n)
        DEINT_PHASE && s_q.cnt == '0 && !HI_SPEED |=>
        ZI_PHASE && s_q.cnt == CNT_W'(ZI_CYC - 1))
        else $error("zero phase length wrong");

    chk_phase_hold: assert property (@(posedge CLK) disable iff (!rst_n)
        s_q.cnt != '0 |=> $stable(s_q.phase))
        else $error("phase moved early");

    chk_meas_fast: assert property (@(posedge CLK) disable iff (!rst_n)
        is_fcnt(FUNC_SEL) && meas_fast |=>
        s_q.mcnt <= scale(MEAS_CYC, 1'b1))
        else $error("fast measurement cycle not taken");

    chk_meas_end: assert property (@(posedge CLK) disable iff (!rst_n)
        is_fcnt(FUNC_SEL) && s_q.mcnt == '0 |=> MEAS_CYCLE_END)
        else $error("measurement cycle end missed");

    // The first decode after reset legitimately moves the outputs
    chk_seg_stable: assert property (@(posedge CLK) disable iff (!rst_n)
        $past(rst_n) &&
        $stable({FUNC_SEL, RANGE_ORDER, AC_MODE, AUTO_RANGE}) |=>
        $stable({ANN_VOLT, ANN_DC, ANN_AC, ANN_MILLI, ANN_KILO}))
        else $error("annunciators moved without cause");

endmodule

// ==== logic/mpac_pkg.sv ====
package mpac_pkg;

    // **************************************************
    // Clock and converter timing
    // **************************************************
    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned HZ_PER_MHZ   = 1_000_000;
    localparam int unsigned CYC_PER_US   = CLK_HZ / HZ_PER_MHZ;
    localparam int unsigned T_ZI_US      = 60_000;
    localparam int unsigned T_AZ_US      = 24_000;
    localparam int unsigned T_INT_US     = 100_000;
    localparam int unsigned T_INT_LONG_US = 1_000_000;
    localparam int unsigned T_DEINTEGRATE_PHASE_US    = 166_000;
    localparam int unsigned T_MEAS_US    = 1_050_000;
    localparam int unsigned ZI_CYC_DEF   = T_ZI_US * CYC_PER_US;
    localparam int unsigned AZ_CYC_DEF   = T_AZ_US * CYC_PER_US;
    localparam int unsigned INT_CYC_DEF  = T_INT_US * CYC_PER_US;
    localparam int unsigned INTL_CYC_DEF = T_INT_LONG_US * CYC_PER_US;
    localparam int unsigned DEINTEGRATE_PHASE_CYC_DEF = T_DEINTEGRATE_PHASE_US * CYC_PER_US;
    localparam int unsigned MEAS_CYC_DEF = T_MEAS_US * CYC_PER_US;
    localparam int unsigned SPEED_RATIO  = 10;
    localparam int unsigned CNT_W        = 26;

    // **************************************************
    // Functions, range orders, phases
    // **************************************************
    typedef enum logic [3:0] {
        FN_VOLT       = 4'h0,
        FN_DIODE      = 4'h1,
        FN_CURR_DMM   = 4'h2,
        FN_CURR_CLAMP = 4'h3,
        FN_OHM        = 4'h4,
        FN_CONT       = 4'h5,
        FN_CAP        = 4'h6,
        FN_FREQ       = 4'h7,
        FN_DUTY       = 4'h8,
        FN_TEMP       = 4'h9,
        FN_ADAPTER_MODE_ONE       = 4'hA,
        FN_ADAPTER_MODE_TWO       = 4'hB,
        FN_ADAPTER_MODE_THREE       = 4'hC,
        FN_ADAPTER_MODE_FOUR       = 4'hD
    } mpac_func_t;

    typedef enum logic [2:0] {
        RO_UNIT  = 3'h0,
        RO_MILLI = 3'h1,
        RO_MICRO = 3'h2,
        RO_NANO  = 3'h3,
        RO_KILO  = 3'h4,
        RO_MEGA  = 3'h5
    } mpac_range_t;

    typedef enum logic [3:0] {
        PH_ZI   = 4'h1,
        PH_AZ   = 4'h2,
        PH_INT  = 4'h4,
        PH_DEINTEGRATE_PHASE = 4'h8
    } mpac_phase_t;

    typedef struct packed {
        logic volt, amp, ohm, farad, cont, diode, pct, hz;
        logic adapter_mode_one, adapter_mode_two, adapter_mode_three, adapter_mode_four, dc, ac, auto_r, manual_range_flag;
        logic hold, relative_function_flag, maxmin, zero, inrush, cap_m, cap_u, cap_n;
        logic va_m, cur_u, meg, kilo, degc, degf, power_off_timer_flag, serial;
    } mpac_seg_t;

endpackage

// ==== tb/mpac_ctrl_bench.sv ====
`timescale 1ns/100ps
module mpac_ctrl_bench
    import mpac_pkg::*;
;
    localparam int ZI = 20, AZ = 30, IN = 40, INL = 100, DI = 60, MC = 50;
    logic CLK = 1'b0, NRST = 1'b0, ac = 1'b0, auto = 1'b0, cel = 1'b0;
    logic hs = 1'b0, chg = 1'b0, done, order_err;
    logic [6:0]  en = 7'h00;
    logic [3:0]  done_ph;
    mpac_func_t  fn = FN_VOLT;
    mpac_range_t rng = RO_UNIT;
    mpac_seg_t   ann, e;
    logic [3:0]  ph;
    logic        mend;
    int          done_len, fail_count = 0, checks_done = 0;

    always #20 CLK = ~CLK;

    mpac_ctrl #(.ZI_CYC(ZI), .AZ_CYC(AZ), .INT_CYC(IN), .INTL_CYC(INL),
        .DEINTEGRATE_PHASE_CYC(DI), .MEAS_CYC(MC)) mpac_ctrl_i (
        .CLK(CLK), .NRST(NRST), .FUNC_SEL(fn), .RANGE_ORDER(rng),
        .AC_MODE(ac), .AUTO_RANGE(auto), .TEMP_CELSIUS(cel), .HI_SPEED(hs),
        .FREQ_RANGE_CHG(chg), .HOLD_EN(en[6]), .REL_EN(en[5]),
        .MAXMIN_EN(en[4]), .ZERO_EN(en[3]), .INRUSH_EN(en[2]),
        .APO_EN(en[1]), .SERIAL_EN(en[0]), .ZI_PHASE(ph[0]),
        .AZ_PHASE(ph[1]), .INT_PHASE(ph[2]), .DEINT_PHASE(ph[3]),
        .MEAS_CYCLE_END(mend), .ANN_VOLT(ann.volt), .ANN_AMP(ann.amp),
        .ANN_OHM(ann.ohm), .ANN_FARAD(ann.farad), .ANN_CONT(ann.cont),
        .ANN_DIODE(ann.diode), .ANN_PCT(ann.pct), .ANN_HZ(ann.hz),
        .ANN_ADAPTER_MODE_ONE(ann.adapter_mode_one), .ANN_ADAPTER_MODE_TWO(ann.adapter_mode_two), .ANN_ADAPTER_MODE_THREE(ann.adapter_mode_three),
        .ANN_ADAPTER_MODE_FOUR(ann.adapter_mode_four), .ANN_DC(ann.dc), .ANN_AC(ann.ac),
        .ANN_AUTO(ann.auto_r), .ANN_MANUAL_RANGE_FLAG(ann.manual_range_flag), .ANN_HOLD(ann.hold),
        .ANN_REL(ann.relative_function_flag), .ANN_MAXMIN(ann.maxmin), .ANN_ZERO(ann.zero),
        .ANN_INRUSH(ann.inrush), .ANN_CAP_MILLI(ann.cap_m),
        .ANN_CAP_MICRO(ann.cap_u), .ANN_CAP_NANO(ann.cap_n),
        .ANN_MILLI(ann.va_m), .ANN_MICRO(ann.cur_u), .ANN_MEGA(ann.meg),
        .ANN_KILO(ann.kilo), .ANN_DEGC(ann.degc), .ANN_DEGF(ann.degf),
        .ANN_APO(ann.power_off_timer_flag), .ANN_SERIAL(ann.serial));

    mpac_front_model mpac_front_model_i (.clk(CLK), .rst_n(NRST),
        .phase(ph), .done(done), .done_ph(done_ph), .done_len(done_len),
        .order_err(order_err));

    // **************************************************
    // Shared tasks
    // **************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
        #2;
    endtask

    // Each wait is bounded; running out ends the run as a failure
    task automatic wait_sig(input bit meas);
        int i;
        for (i = 0; i < 1000; i++) begin
            @(posedge CLK);
            #1;
            if ((meas ? mend : done) === 1'b1) break;
        end
        if (i == 1000) begin
            fail_count++;
            complete_run();
        end
    endtask

    task automatic meas_gap(input int exp);
        int n;
        wait_sig(1'b1);
        wait_sig(1'b1);
        for (n = 1; n < 1000; n++) begin
            @(posedge CLK);
            #1;
            if (mend === 1'b1) break;
        end
        check(n, exp);
        #1;
    endtask

    function automatic mpac_seg_t exp_ann();
        mpac_seg_t r;
        logic      cur, vc;
        r = '0;
        cur = (fn == FN_CURR_DMM) || (fn == FN_CURR_CLAMP);
        vc = cur || (fn == FN_VOLT);
        r.volt = (fn == FN_VOLT) || (fn == FN_DIODE);
        r.amp = cur;
        r.ohm = (fn == FN_OHM) || (fn == FN_CONT);
        r.farad = (fn == FN_CAP);
        r.cont = (fn == FN_CONT);
        r.diode = (fn == FN_DIODE);
        r.pct = (fn == FN_DUTY);
        r.hz = (fn == FN_FREQ);
        {r.adapter_mode_one, r.adapter_mode_two, r.adapter_mode_three, r.adapter_mode_four} = 4'h8 >> (fn - FN_ADAPTER_MODE_ONE);
        if (fn < FN_ADAPTER_MODE_ONE) {r.adapter_mode_one, r.adapter_mode_two, r.adapter_mode_three, r.adapter_mode_four} = 4'h0;
        r.dc = vc && !ac;
        r.ac = vc && ac;
        r.auto_r = auto;
        r.manual_range_flag = !auto;
        {r.hold, r.relative_function_flag, r.maxmin, r.zero, r.inrush, r.power_off_timer_flag, r.serial} = en;
        r.cap_m = (fn == FN_CAP) && (rng == RO_MILLI);
        r.cap_u = (fn == FN_CAP) && (rng == RO_MICRO);
        r.cap_n = (fn == FN_CAP) && (rng == RO_NANO);
        r.va_m = vc && (rng == RO_MILLI);
        r.cur_u = cur && (rng == RO_MICRO);
        r.meg = (fn == FN_OHM) && (rng == RO_MEGA);
        r.kilo = (fn == FN_OHM) && (rng == RO_KILO);
        r.degc = (fn == FN_TEMP) && cel;
        r.degf = (fn == FN_TEMP) && !cel;
        return r;
    endfunction

    // **************************************************
    // Main sequence
    // **************************************************
    // Function, auto, speed per phase scenario; integrate lengths follow
    mpac_func_t cf[5] = '{FN_VOLT, FN_CURR_DMM, FN_CURR_CLAMP,
        FN_CURR_CLAMP, FN_ADAPTER_MODE_ONE};
    bit ca[5] = '{1, 0, 1, 0, 0};
    bit ch[5] = '{0, 0, 1, 1, 1};
    int ci[5] = '{IN, INL, INL, IN, IN};

    initial begin
        int d, k, n;
        tick(20);
        NRST = 1'b1;
        tick(4);
        for (int f = 0; f < 14; f++) begin
            for (int r = 0; r < 6; r++) begin
                if (f == 5 && r >= 4) continue;
                fn = mpac_func_t'(f);
                rng = mpac_range_t'(r);
                ac = r[0];
                cel = r[0];
                auto = f[0] ^ r[1];
                en = 7'(f * 6 + r);
                tick(2);
                e = exp_ann();
                check(ann[31:24], e[31:24]);
                check(ann, e);
                check(ann[23:16], e[23:16]);
                check(ann[15:8], e[15:8]);
                check(ann[7:0], e[7:0]);
            end
        end
        for (int c = 0; c < 5; c++) begin
            fn = cf[c];
            auto = ca[c];
            hs = ch[c];
            d = hs ? 10 : 1;
            for (k = 0; k < 8; k++) begin
                wait_sig(1'b0);
                if (done_ph === PH_DEINTEGRATE_PHASE) break;
            end
            foreach (cf[j]) if (j < 4) begin
                wait_sig(1'b0);
                check(done_ph, 4'h1 << j);
                n = (j == 0) ? ZI : (j == 1) ? AZ : (j == 2) ? ci[c] : DI;
                check(done_len, n / d);
            end
            #1;
        end
        check(order_err, 1'b0);
        hs = 1'b0;
        fn = FN_FREQ;
        auto = 1'b1;
        meas_gap(MC);
        chg = 1'b1;
        meas_gap(MC / 10);
        fn = FN_DUTY;
        auto = 1'b0;
        meas_gap(MC);
        fn = FN_VOLT;
        tick(2);
        n = 0;
        repeat (150) begin
            tick(1);
            if (mend !== 1'b0) n++;
        end
        check(n, 0);
        complete_run();
    end
endmodule

// ==== tb/mpac_front_model.sv ====
`timescale 1ns/100ps
module mpac_front_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Phase strobes from the controller
    input  wire logic [3:0] phase,
    // Observed phase lengths
    output logic            done,
    output logic [3:0]      done_ph,
    output int              done_len,
    output logic            order_err
);
    logic [3:0] prev_q;
    int         cnt_q;

    // **************************************************
    // Integrator phase watcher
    // **************************************************
    // Counts how long the integrator was held in each phase, so the
    // bench sees whole phase lengths rather than sampling strobes itself
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q    <= 4'h1;
            cnt_q     <= 0;
            done      <= 1'b0;
            done_ph   <= 4'h0;
            done_len  <= 0;
            order_err <= 1'b0;
        end else begin
            prev_q <= phase;
            done   <= (phase !== prev_q);
            if (phase !== prev_q) begin
                done_ph  <= prev_q;
                done_len <= cnt_q;
                cnt_q    <= 1;
                // Only ZI, AZ, INT, DEINTEGRATE_PHASE and back to ZI is a legal step
                if (phase !== {prev_q[2:0], prev_q[3]}) begin
                    order_err <= 1'b1;
                end
            end else begin
                cnt_q <= cnt_q + 1;
            end
        end
    end
endmodule
